// [rtl/ienm_pkg.sv]
package ienm_pkg;

  // ==========================================================================
  // Sizes
  // ==========================================================================
  // Number of CPU vectors that the enable masks gate.
  localparam int unsigned IENM_NUM_SRC  = 18;
  // Width of the register port.
  localparam int unsigned IENM_DATA_W   = 8;
  localparam int unsigned IENM_ADDR_W   = 8;

  // ==========================================================================
  // Register offsets
  // ==========================================================================
  localparam logic [7:0] IENM_OFS_GROUP_A = 8'ha8;
  localparam logic [7:0] IENM_OFS_GROUP_B = 8'hb8;
  localparam logic [7:0] IENM_OFS_GROUP_C = 8'h9a;
  localparam logic [7:0] IENM_OFS_STATUS  = 8'hf0;
  localparam logic [7:0] IENM_OFS_MASK    = 8'hf1;

  // ==========================================================================
  // Reset values and write masks
  // ==========================================================================
  localparam logic [7:0] IENM_RST_GROUP_A = 8'h00;
  localparam logic [7:0] IENM_RST_GROUP_B = 8'h00;
  localparam logic [7:0] IENM_RST_GROUP_C = 8'h00;
  localparam logic [7:0] IENM_RST_STATUS  = 8'h00;
  localparam logic [7:0] IENM_RST_MASK    = 8'h00;
  localparam logic [7:0] IENM_WMASK_A     = 8'hff;
  localparam logic [7:0] IENM_WMASK_B     = 8'hbf;
  localparam logic [7:0] IENM_WMASK_C     = 8'hff;
  localparam logic [7:0] IENM_STATUS_USED = 8'h07;

  // ==========================================================================
  // Field positions
  // ==========================================================================
  localparam int unsigned IENM_A_GLOBAL          = 7;
  localparam int unsigned IENM_A_SLEEP_TIMER     = 5;
  localparam int unsigned IENM_A_AES             = 4;
  localparam int unsigned IENM_A_SERIAL1_RX      = 3;
  localparam int unsigned IENM_A_SERIAL0_RX      = 2;
  localparam int unsigned IENM_A_CONVERTER       = 1;
  localparam int unsigned IENM_A_RADIO_DONE      = 0;
  localparam int unsigned IENM_B_RO_ZERO         = 6;
  localparam int unsigned IENM_B_PORT_A          = 5;
  localparam int unsigned IENM_B_TIMER_D         = 4;
  localparam int unsigned IENM_B_TIMER_C         = 3;
  localparam int unsigned IENM_B_TIMER_B         = 2;
  localparam int unsigned IENM_B_TIMER_A         = 1;
  localparam int unsigned IENM_B_TRANSFER_DONE   = 0;
  localparam int unsigned IENM_C_WATCHDOG        = 5;
  localparam int unsigned IENM_C_PORT_B          = 4;
  localparam int unsigned IENM_C_SERIAL1_TX      = 3;
  localparam int unsigned IENM_C_SERIAL0_TX      = 2;
  localparam int unsigned IENM_C_PORT_C          = 1;
  localparam int unsigned IENM_C_RADIO_GENERAL   = 0;
  localparam int unsigned IENM_ST_FORWARD        = 0;
  localparam int unsigned IENM_ST_GLOBAL_BLOCK   = 1;
  localparam int unsigned IENM_ST_SOURCE_BLOCK   = 2;

  // ==========================================================================
  // Vector numbers
  // ==========================================================================
  localparam int unsigned IENM_VEC_RADIO_DONE    = 0;
  localparam int unsigned IENM_VEC_CONVERTER     = 1;
  localparam int unsigned IENM_VEC_SERIAL0_RX    = 2;
  localparam int unsigned IENM_VEC_SERIAL1_RX    = 3;
  localparam int unsigned IENM_VEC_AES           = 4;
  localparam int unsigned IENM_VEC_SLEEP_TIMER   = 5;
  localparam int unsigned IENM_VEC_PORT_C        = 6;
  localparam int unsigned IENM_VEC_SERIAL0_TX    = 7;
  localparam int unsigned IENM_VEC_TRANSFER_DONE = 8;
  localparam int unsigned IENM_VEC_TIMER_A       = 9;
  localparam int unsigned IENM_VEC_TIMER_B       = 10;
  localparam int unsigned IENM_VEC_TIMER_C       = 11;
  localparam int unsigned IENM_VEC_TIMER_D       = 12;
  localparam int unsigned IENM_VEC_PORT_A        = 13;
  localparam int unsigned IENM_VEC_SERIAL1_TX    = 14;
  localparam int unsigned IENM_VEC_PORT_B        = 15;
  localparam int unsigned IENM_VEC_RADIO_GENERAL = 16;
  localparam int unsigned IENM_VEC_WATCHDOG      = 17;

endpackage

// [rtl/ienm_gate_if.sv]
`timescale 1ns/100ps
`default_nettype none

// ============================================================================
// Gate bundle between the register core and the request gate.
// ============================================================================
interface ienm_gate_if #(
  parameter int unsigned N = 18
);
  logic [N-1:0] allow;        // Per-source enable bits.
  logic [N-1:0] flag;         // Combined per-vector pending flags.
  logic         global_allow; // Global enable bit.
  logic [N-1:0] req;          // Registered requests toward the CPU.
  logic [N-1:0] pend;         // Registered raw flags, enable ignored.

  // The register core drives the masks and flags.
  modport core (output allow, output flag, output global_allow, input req, input pend);
  // The gate drives the requests.
  modport gate (input allow, input flag, input global_allow, output req, output pend);
endinterface

`default_nettype wire

// [rtl/ienm_gate.sv]
`timescale 1ns/100ps
`default_nettype none

// ============================================================================
// Request gate: one flip-flop stage from flag to CPU request.
// ============================================================================
module ienm_gate #(
  parameter int unsigned N = 18
) (
  input  wire logic i_core_clk,
  input  wire logic i_rst,
  ienm_gate_if.gate gif
);

  // A gate with no sources cannot be built.
  if (N < 1) begin : g_bad_n
    $error("ienm_gate needs at least one source");
  end

  // Combinational request: global AND own enable AND flag.
  wire logic [N-1:0] next_req;
  assign next_req = gif.flag & gif.allow & {N{gif.global_allow}};

  // The request is taken by the CPU one cycle later, on its next cycle.
  always_ff @(posedge i_core_clk) begin
    if (i_rst) begin
      gif.req  <= '0;
      gif.pend <= '0;
    end else begin
      gif.req  <= next_req;
      gif.pend <= gif.flag;
    end
  end

  // ==========================================================================
  // Checks
  // ==========================================================================
  default clocking cb @(posedge i_core_clk); endclocking
  default disable iff (i_rst);

  chk_global_off_quiet: assert property (!gif.global_allow |=> gif.req == '0)
    else $error("request seen while global enable clear");
  chk_flag_no_enable: assert property (##1 gif.pend == $past(gif.flag))
    else $error("pending flag did not follow source flag");

endmodule

`default_nettype wire

// [rtl/ienm_core.sv]
`timescale 1ns/100ps
`default_nettype none

// How it works
// - Global enable clear blocks every request.
// - Global set: each source follows own bit.
// - Group A layout at its offset.
// - Group B layout, bit six reads zero.
// - Group C layout at its offset.
// - Zero blocks, one permits, reset clears.
// - One bit gates serial1 and audio receive.
// - One bit gates serial1 and audio transmit.
// - Port C bit also gates host link.
// - Audio unit masks its own flags.
// - Host link flag prequalified by its masks.
// - Flags pass regardless of enable bits.
// - Request reaches CPU next cycle.

// ============================================================================
// Interrupt enable masks: registers, flag combining and request gating.
// ============================================================================
module ienm_core
  import ienm_pkg::*;
#(
  parameter int unsigned NUM_SRC       = IENM_NUM_SRC, // Vectors gated.
  parameter bit          HAS_HOST_LINK = 1'b1          // Variant with host link.
) (
  input  wire logic                    i_core_clk,
  input  wire logic                    i_rst,
  input  wire logic [IENM_ADDR_W-1:0]  i_addr,
  input  wire logic [IENM_DATA_W-1:0]  i_wr_data,
  input  wire logic                    i_wr_en,
  input  wire logic                    i_rd_en,
  output var  logic [IENM_DATA_W-1:0]  o_rd_data,
  input  wire logic [NUM_SRC-1:0]      i_src_flag,
  input  wire logic                    i_audio_rx_flag,
  input  wire logic                    i_audio_tx_flag,
  input  wire logic                    i_host_link_flag,
  output var  logic [NUM_SRC-1:0]      o_cpu_req,
  output var  logic [NUM_SRC-1:0]      o_pending,
  output var  logic                    o_cpu_req_any,
  output var  logic                    o_irq
);

  // The bit mapping below is fixed to eighteen vectors.
  if (NUM_SRC != IENM_NUM_SRC) begin : g_bad_num
    $error("ienm_core supports exactly eighteen sources");
  end

  // ==========================================================================
  // Storage
  // ==========================================================================
  logic [7:0] group_a;    // Global enable and first six source enables.
  logic [7:0] group_b;    // Port A, timers and transfer-done enables.
  logic [7:0] group_c;    // Watchdog, ports, serial transmit, radio.
  logic [7:0] irq_status; // Sticky event bits, cleared by a read.
  logic [7:0] irq_mask;   // Mask of the same layout as the status.
  logic [NUM_SRC-1:0] flag_q;  // Previous combined flags for edge finding.
  logic [NUM_SRC-1:0] req_q;   // Previous requests for edge finding.

  // ==========================================================================
  // Address decode
  // ==========================================================================
  wire logic sel_a;
  wire logic sel_b;
  wire logic sel_c;
  wire logic sel_status;
  wire logic sel_mask;
  wire logic sel_any;

  assign sel_a      = (i_addr == IENM_OFS_GROUP_A);
  assign sel_b      = (i_addr == IENM_OFS_GROUP_B);
  assign sel_c      = (i_addr == IENM_OFS_GROUP_C);
  assign sel_status = (i_addr == IENM_OFS_STATUS);
  assign sel_mask   = (i_addr == IENM_OFS_MASK);
  assign sel_any    = sel_a | sel_b | sel_c | sel_status | sel_mask;

  // Write strobes per register.
  wire logic wr_a;
  wire logic wr_b;
  wire logic wr_c;
  wire logic wr_mask;

  assign wr_a    = i_wr_en & sel_a;
  assign wr_b    = i_wr_en & sel_b;
  assign wr_c    = i_wr_en & sel_c;
  assign wr_mask = i_wr_en & sel_mask;

  // A status read clears the sticky bits after the value is captured.
  wire logic rd_status;
  assign rd_status = i_rd_en & sel_status;

  // ==========================================================================
  // Enable registers
  // ==========================================================================
  // Every enable starts at zero so no vector fires before software is ready.
  // Bit six of group B is held at zero by its write mask and never stores.
  always_ff @(posedge i_core_clk) begin
    if (i_rst) begin
      group_a <= IENM_RST_GROUP_A;
      group_b <= IENM_RST_GROUP_B;
      group_c <= IENM_RST_GROUP_C;
    end else begin
      if (wr_a) begin
        group_a <= i_wr_data & IENM_WMASK_A;
      end
      if (wr_b) begin
        group_b <= i_wr_data & IENM_WMASK_B;
      end
      if (wr_c) begin
        group_c <= i_wr_data & IENM_WMASK_C;
      end
    end
  end

  // ==========================================================================
  // Per-vector enable map
  // ==========================================================================
  wire logic [NUM_SRC-1:0] src_allow;
  wire logic               global_allow;
  assign global_allow = group_a[IENM_A_GLOBAL];

  assign src_allow[IENM_VEC_RADIO_DONE]    = group_a[IENM_A_RADIO_DONE];
  assign src_allow[IENM_VEC_CONVERTER]     = group_a[IENM_A_CONVERTER];
  assign src_allow[IENM_VEC_SERIAL0_RX]    = group_a[IENM_A_SERIAL0_RX];
  assign src_allow[IENM_VEC_SERIAL1_RX]    = group_a[IENM_A_SERIAL1_RX];
  assign src_allow[IENM_VEC_AES]           = group_a[IENM_A_AES];
  assign src_allow[IENM_VEC_SLEEP_TIMER]   = group_a[IENM_A_SLEEP_TIMER];
  assign src_allow[IENM_VEC_PORT_C]        = group_c[IENM_C_PORT_C];
  assign src_allow[IENM_VEC_SERIAL0_TX]    = group_c[IENM_C_SERIAL0_TX];
  assign src_allow[IENM_VEC_TRANSFER_DONE] = group_b[IENM_B_TRANSFER_DONE];
  assign src_allow[IENM_VEC_TIMER_A]       = group_b[IENM_B_TIMER_A];
  assign src_allow[IENM_VEC_TIMER_B]       = group_b[IENM_B_TIMER_B];
  assign src_allow[IENM_VEC_TIMER_C]       = group_b[IENM_B_TIMER_C];
  assign src_allow[IENM_VEC_TIMER_D]       = group_b[IENM_B_TIMER_D];
  assign src_allow[IENM_VEC_PORT_A]        = group_b[IENM_B_PORT_A];
  assign src_allow[IENM_VEC_SERIAL1_TX]    = group_c[IENM_C_SERIAL1_TX];
  assign src_allow[IENM_VEC_PORT_B]        = group_c[IENM_C_PORT_B];
  assign src_allow[IENM_VEC_RADIO_GENERAL] = group_c[IENM_C_RADIO_GENERAL];
  assign src_allow[IENM_VEC_WATCHDOG]      = group_c[IENM_C_WATCHDOG];

  // ==========================================================================
  // Shared-vector flag combining
  // ==========================================================================
  // The audio unit has already applied its own enables, so its flags are
  // merged as they come; no second mask stands inside this block for them.
  // The host link flag arrives already gated by the peripheral's own masks
  // and only meets the CPU-level enable here.
  wire logic host_link_used;
  assign host_link_used = HAS_HOST_LINK & i_host_link_flag;

  wire logic [NUM_SRC-1:0] shared_flag;
  assign shared_flag[IENM_VEC_SERIAL1_RX] = i_audio_rx_flag;
  assign shared_flag[IENM_VEC_SERIAL1_TX] = i_audio_tx_flag;
  assign shared_flag[IENM_VEC_PORT_C]     = host_link_used;
  // Vectors with no second source take no extra flag.
  assign shared_flag[IENM_VEC_SERIAL0_RX:IENM_VEC_RADIO_DONE]            = '0;
  assign shared_flag[IENM_VEC_SLEEP_TIMER:IENM_VEC_AES]                  = '0;
  assign shared_flag[IENM_VEC_SERIAL1_TX-1:IENM_VEC_SERIAL0_TX]          = '0;
  assign shared_flag[NUM_SRC-1:IENM_VEC_PORT_B]                          = '0;

  // Combined flags; no enable takes part so they always reach the pending view.
  wire logic [NUM_SRC-1:0] comb_flag;
  assign comb_flag = i_src_flag | shared_flag;

  // ==========================================================================
  // Request gate
  // ==========================================================================
  ienm_gate_if #(.N(NUM_SRC)) gif ();

  assign gif.allow        = src_allow;
  assign gif.flag         = comb_flag;
  assign gif.global_allow = global_allow;

  ienm_gate #(
    .N (NUM_SRC)
  ) u_gate (
    .i_core_clk (i_core_clk),
    .i_rst      (i_rst),
    .gif        (gif)
  );

  assign o_cpu_req     = gif.req;
  assign o_pending     = gif.pend;
  assign o_cpu_req_any = |gif.req;

  // ==========================================================================
  // Event detection for the status register
  // ==========================================================================
  // Only rising edges count: a level flag that stays high would otherwise
  // set the sticky bit again right after every status read.
  wire logic [NUM_SRC-1:0] flag_rise;
  wire logic [NUM_SRC-1:0] req_rise;
  wire logic [7:0]         status_set;

  assign flag_rise = comb_flag & ~flag_q;
  assign req_rise  = gif.req & ~req_q;
  assign status_set[IENM_ST_FORWARD]      = |req_rise;
  assign status_set[IENM_ST_GLOBAL_BLOCK] = (|flag_rise) & ~global_allow;
  assign status_set[IENM_ST_SOURCE_BLOCK] = (|(flag_rise & ~src_allow)) & global_allow;
  assign status_set[7:3]                  = '0;

  // Set wins over the clear of a read in the same cycle.
  wire logic [7:0] next_status;
  assign next_status = ((rd_status ? 8'h00 : irq_status) | status_set) & IENM_STATUS_USED;

  // Edge history, status and mask.
  always_ff @(posedge i_core_clk) begin
    if (i_rst) begin
      flag_q     <= '0;
      req_q      <= '0;
      irq_status <= IENM_RST_STATUS;
      irq_mask   <= IENM_RST_MASK;
    end else begin
      flag_q     <= comb_flag;
      req_q      <= gif.req;
      irq_status <= next_status;
      if (wr_mask) begin
        irq_mask <= i_wr_data & IENM_STATUS_USED;
      end
    end
  end

  // Level interrupt, high while any unmasked status bit is set.
  assign o_irq = |(irq_status & irq_mask);

  // ==========================================================================
  // Read port
  // ==========================================================================
  // Unmapped addresses read zero; data stand only in the cycle after the strobe.
  wire logic [7:0] rd_mux;
  assign rd_mux = sel_a      ? group_a    :
                  sel_b      ? group_b    :
                  sel_c      ? group_c    :
                  sel_status ? irq_status :
                  sel_mask   ? irq_mask   : 8'h00;

  // Read data register.
  always_ff @(posedge i_core_clk) begin
    if (i_rst) begin
      o_rd_data <= 8'h00;
    end else if (i_rd_en && sel_any) begin
      o_rd_data <= rd_mux;
    end else begin
      o_rd_data <= 8'h00;
    end
  end

  // ==========================================================================
  // Checks
  // ==========================================================================
  default clocking cb @(posedge i_core_clk); endclocking
  default disable iff (i_rst);

  // Requests are judged one edge after the enables and flags behind them.
  chk_global_blocks_all: assert property (!global_allow |=> o_cpu_req == '0)
    else $error("request forwarded with global enable clear");

  chk_own_bit_rules: assert property (global_allow |=> o_cpu_req == $past(src_allow & comb_flag))
    else $error("request does not follow own enable bit");

  chk_group_a_read: assert property (i_rd_en && sel_a |=> o_rd_data == $past(group_a))
    else $error("group A read data wrong");

  chk_group_b_bit6: assert property (group_b[IENM_B_RO_ZERO] == 1'b0)
    else $error("group B bit six not zero");

  chk_group_c_write: assert property (wr_c ##1 (i_rd_en && sel_c) |=> o_rd_data == $past(i_wr_data, 2))
    else $error("group C write not read back");

  chk_reset_clears: assert property (@(posedge i_core_clk) $past(i_rst) |-> (group_a | group_b | group_c) == 8'h00)
    else $error("enable not zero after reset");

  chk_audio_rx_shared: assert property (global_allow && group_a[IENM_A_SERIAL1_RX] && i_audio_rx_flag
                                        |=> o_cpu_req[IENM_VEC_SERIAL1_RX])
    else $error("audio receive not forwarded on shared vector");

  chk_audio_tx_shared: assert property (global_allow && group_c[IENM_C_SERIAL1_TX] && i_audio_tx_flag
                                        |=> o_cpu_req[IENM_VEC_SERIAL1_TX])
    else $error("audio transmit not forwarded on shared vector");

  chk_host_link_shared: assert property (HAS_HOST_LINK && global_allow && group_c[IENM_C_PORT_C] && i_host_link_flag
                                         |=> o_cpu_req[IENM_VEC_PORT_C])
    else $error("host link not forwarded on shared vector");

  chk_pending_raw: assert property (##1 o_pending == $past(comb_flag))
    else $error("pending view depends on enables");

  chk_status_sticky: assert property (irq_status[IENM_ST_FORWARD] && !rd_status |=> irq_status[IENM_ST_FORWARD])
    else $error("sticky status bit lost without a read");

  chk_audio_rx_blocked: assert property (!group_a[IENM_A_SERIAL1_RX] |=> !o_cpu_req[IENM_VEC_SERIAL1_RX])
    else $error("shared receive vector forwarded with its bit clear");

  // Main scenarios the bench is expected to reach.
  cov_request_forwarded: cover property (global_allow ##1 o_cpu_req_any);
  cov_status_read_clear: cover property (o_irq && rd_status ##1 !o_irq);
  cov_audio_shared_req:  cover property (i_audio_rx_flag && !i_src_flag[IENM_VEC_SERIAL1_RX] ##1 o_cpu_req[IENM_VEC_SERIAL1_RX]);
  cov_global_block_evt:  cover property (status_set[IENM_ST_GLOBAL_BLOCK]);

endmodule

`default_nettype wire

// [dv/ienm_src_model.sv]
`timescale 1ns/100ps
`default_nettype none

// ==========================================================================
// Peripheral flag sources: one flag flop per source, commanded by the bench.
// ==========================================================================
module ienm_src_model (
  input  wire logic        i_core_clk,       // Core clock.
  input  wire logic        i_rst,            // Synchronous reset.
  input  wire logic [20:0] i_raw,            // Events: 17:0 vectors, 18 audio rx, 19 audio tx, 20 host link.
  input  wire logic [2:0]  i_unit_allow,     // Peripheral-side enables: audio rx, audio tx, host link.
  output logic      [17:0] o_src_flag,       // Per-vector flags.
  output logic             o_audio_rx_flag,  // Audio receive flag.
  output logic             o_audio_tx_flag,  // Audio transmit flag.
  output logic             o_host_link_flag  // Host link flag.
);
  // Flags are flops, as in a real peripheral, so they never change between edges.
  always_ff @(posedge i_core_clk) begin
    if (i_rst) begin
      o_src_flag       <= 18'h00000;
      o_audio_rx_flag  <= 1'b0;
      o_audio_tx_flag  <= 1'b0;
      o_host_link_flag <= 1'b0;
    end else begin
      o_src_flag       <= i_raw[17:0];
      o_audio_rx_flag  <= i_raw[18] & i_unit_allow[0];
      o_audio_tx_flag  <= i_raw[19] & i_unit_allow[1];
      o_host_link_flag <= i_raw[20] & i_unit_allow[2];
    end
  end
endmodule

`default_nettype wire

// [dv/interrupt_enable_masks_test.sv]
`timescale 1ns/100ps
`default_nettype none

// ==========================================================================
// Self-checking bench for the interrupt enable masks.
// ==========================================================================
module interrupt_enable_masks_test import ienm_pkg::*;;
  typedef struct packed {
    logic [7:0]  a, b, c;    // Group A, B and C values.
    logic [17:0] flag, exp;  // Flags driven and requests expected.
  } ienm_row_t;
  logic        i_core_clk, i_rst, i_wr_en, i_rd_en;
  logic [7:0]  i_addr, i_wr_data, o_rd_data, d;
  logic [20:0] raw;
  logic [2:0]  unit_allow;
  logic [17:0] src_flag, o_cpu_req, o_pending;
  logic        rx_flag, tx_flag, host_flag, o_cpu_req_any, o_irq;
  int          err_total, checks_done, cycles;
  logic [7:0]  ofs [4] = '{IENM_OFS_GROUP_A, IENM_OFS_GROUP_B, IENM_OFS_GROUP_C, IENM_OFS_MASK};
  logic [7:0]  acc_ofs [4] = '{8'ha8, 8'hb8, 8'h9a, 8'h55};
  logic [7:0]  acc_exp [4] = '{8'hff, 8'hbf, 8'hff, 8'h00};
  // Ordinary cases: enables and flags beside the requests they must give.
  ienm_row_t   rows [8] = '{
    '{8'h7f, 8'h3f, 8'h3f, 18'h3ffff, 18'h00000}, '{8'hff, 8'hff, 8'hff, 18'h3ffff, 18'h3ffff},
    '{8'h80, 8'h00, 8'h00, 18'h3ffff, 18'h00000}, '{8'hbf, 8'h00, 8'h00, 18'h3ffff, 18'h0003f},
    '{8'h80, 8'h3f, 8'h00, 18'h3ffff, 18'h03f00}, '{8'h80, 8'h00, 8'h3f, 18'h3ffff, 18'h3c0c0},
    '{8'hff, 8'hff, 8'hff, 18'h2a5a5, 18'h2a5a5}, '{8'h81, 8'h01, 8'h01, 18'h10101, 18'h10101}};

  ienm_src_model SRC (.i_core_clk(i_core_clk), .i_rst(i_rst), .i_raw(raw), .i_unit_allow(unit_allow),
    .o_src_flag(src_flag), .o_audio_rx_flag(rx_flag), .o_audio_tx_flag(tx_flag), .o_host_link_flag(host_flag));
  ienm_core DUT (.i_core_clk(i_core_clk), .i_rst(i_rst), .i_addr(i_addr), .i_wr_data(i_wr_data),
    .i_wr_en(i_wr_en), .i_rd_en(i_rd_en), .o_rd_data(o_rd_data), .i_src_flag(src_flag),
    .i_audio_rx_flag(rx_flag), .i_audio_tx_flag(tx_flag), .i_host_link_flag(host_flag),
    .o_cpu_req(o_cpu_req), .o_pending(o_pending), .o_cpu_req_any(o_cpu_req_any), .o_irq(o_irq));

  // ==========================================================================
  // Clock, bus tasks and comparisons.
  // ==========================================================================
  initial begin
    i_core_clk = 1'b0;
    forever #2 i_core_clk = ~i_core_clk;
  end
  // One-cycle write strobe; the register holds the value after the strobe edge.
  task automatic wr(input logic [7:0] a, input logic [7:0] v);
    @(posedge i_core_clk);
    i_wr_en <= 1'b1; i_addr <= a; i_wr_data <= v;
    @(posedge i_core_clk);
    i_wr_en <= 1'b0;
  endtask
  // Read data stand only in the cycle after the strobe, so they are taken there.
  task automatic rd(input logic [7:0] a, output logic [7:0] v);
    @(posedge i_core_clk);
    i_rd_en <= 1'b1; i_addr <= a;
    @(posedge i_core_clk);
    i_rd_en <= 1'b0;
    #1 v = o_rd_data;
  endtask
  task automatic chk_byte(input logic [7:0] got, input logic [7:0] exp);
    checks_done++;
    if (got !== exp) begin err_total++; $display("Error at %0t: got %h expected %h", $time, got, exp); end
  endtask
  task automatic chk_vec(input logic [17:0] got, input logic [17:0] exp);
    checks_done++;
    if (got !== exp) begin err_total++; $display("Error at %0t: got %h expected %h", $time, got, exp); end
  endtask
  task automatic chk_bit(input logic got, input logic exp);
    checks_done++;
    if (got !== exp) begin err_total++; $display("Error at %0t: got %h expected %h", $time, got, exp); end
  endtask
  // Every enable and the mask must read zero, with nothing requested.
  task automatic check_cleared();
    for (int k = 0; k < 4; k++) begin
      rd(ofs[k], d);
      chk_byte(d, 8'h00);
    end
    chk_vec(o_cpu_req, 18'h00000);
    chk_bit(o_irq, 1'b0);
  endtask
  task automatic finish_test();
    $display("Checks %0d, errors %0d", checks_done, err_total);
    if (err_total == 0 && checks_done > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  // A hang is cut off far beyond the fewer than two hundred cycles the run needs.
  always @(posedge i_core_clk) begin
    cycles++;
    if (cycles == 5000) begin err_total++; finish_test(); end
  end

  // ==========================================================================
  // Main sequence.
  // ==========================================================================
  initial begin
    i_rst = 1'b1; i_wr_en = 1'b0; i_rd_en = 1'b0; i_addr = 8'h00; i_wr_data = 8'h00;
    raw = 21'h000000; unit_allow = 3'h0; err_total = 0; checks_done = 0; cycles = 0;
    repeat (12) @(posedge i_core_clk);
    i_rst <= 1'b0;
    check_cleared();
    // Storage of each group, the read-only bit and an unmapped place.
    for (int k = 0; k < 4; k++) begin
      wr(acc_ofs[k], 8'hff); rd(acc_ofs[k], d);
      chk_byte(d, acc_exp[k]);
    end
    wr(IENM_OFS_MASK, 8'hff); rd(IENM_OFS_MASK, d);
    chk_byte(d, 8'h07);
    // A reset in mid-run must clear what was written.
    @(posedge i_core_clk); i_rst <= 1'b1; @(posedge i_core_clk); i_rst <= 1'b0;
    check_cleared();
    // Table of ordinary gating cases: flag reaches the core one edge after the command, the request two edges after.
    foreach (rows[i]) begin
      wr(IENM_OFS_GROUP_A, rows[i].a); wr(IENM_OFS_GROUP_B, rows[i].b); wr(IENM_OFS_GROUP_C, rows[i].c);
      raw <= {3'b000, rows[i].flag};
      repeat (2) @(posedge i_core_clk);
      #1 chk_vec(o_cpu_req, rows[i].exp);
      chk_vec(o_pending, rows[i].flag);
      chk_bit(o_cpu_req_any, |rows[i].exp);
    end
    // Shared vectors: one enable each serves two sources.
    raw <= 21'h1c0000; unit_allow <= 3'h7;
    wr(IENM_OFS_GROUP_A, 8'h88); wr(IENM_OFS_GROUP_B, 8'h00); wr(IENM_OFS_GROUP_C, 8'h0a);
    @(posedge i_core_clk);
    #1 chk_vec(o_cpu_req, 18'h04048);
    wr(IENM_OFS_GROUP_C, 8'h00); @(posedge i_core_clk);
    #1 chk_vec(o_cpu_req, 18'h00008);
    unit_allow <= 3'h0; repeat (2) @(posedge i_core_clk);
    #1 chk_vec(o_cpu_req, 18'h00000);
    // Status events, mask and read-clear of the interrupt output.
    raw <= 21'h000000; wr(IENM_OFS_GROUP_A, 8'h80); wr(IENM_OFS_MASK, 8'h07); rd(IENM_OFS_STATUS, d);
    raw <= 21'h000001; repeat (4) @(posedge i_core_clk);
    #1 chk_bit(o_irq, 1'b1);
    rd(IENM_OFS_STATUS, d); chk_byte(d, 8'h04);
    chk_bit(o_irq, 1'b0);
    raw <= 21'h000000; wr(IENM_OFS_GROUP_A, 8'h00); raw <= 21'h000001; repeat (4) @(posedge i_core_clk);
    rd(IENM_OFS_STATUS, d); chk_byte(d, 8'h02);
    raw <= 21'h000000; wr(IENM_OFS_GROUP_A, 8'h81); wr(IENM_OFS_MASK, 8'h00); raw <= 21'h000001;
    repeat (4) @(posedge i_core_clk);
    #1 chk_bit(o_irq, 1'b0);
    wr(IENM_OFS_MASK, 8'h01);
    #1 chk_bit(o_irq, 1'b1);
    rd(IENM_OFS_STATUS, d); chk_byte(d, 8'h01);
    // Clearing the global bit drops a standing request at the next edge.
    wr(IENM_OFS_GROUP_A, 8'h01); @(posedge i_core_clk);
    #1 chk_vec(o_cpu_req, 18'h00000);
    // A request follows its flag by exactly one edge.
    raw <= 21'h000000; wr(IENM_OFS_GROUP_A, 8'h81); raw <= 21'h000001;
    @(posedge i_core_clk);
    #1 chk_bit(o_cpu_req_any, 1'b0);
    @(posedge i_core_clk);
    #1 chk_bit(o_cpu_req_any, 1'b1);
    finish_test();
  end
endmodule

`default_nettype wire
